// [common/rcr_pkg.sv]
package rcr_pkg;
   // ==========================================
   // register map
   localparam logic [3:0] ADDR_FLAGS = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
   localparam logic [3:0] ADDR_PC = 4'h4;

   // ==========================================
   // flag bit positions
   localparam int BIT_OVF = 7;
   localparam int BIT_UNF = 6;
   localparam int BIT_PIN = 3;
   localparam int BIT_INSTR = 2;
   localparam int BIT_POR = 1;
   localparam int BIT_BOR = 0;
   localparam logic [7:0] FLAGS_IMPL_MASK = 8'hcf;
   localparam logic [7:0] FLAGS_POR_VAL = 8'h0c;
   localparam logic [7:0] FLAGS_POR_KEEP = 8'h00;
   localparam logic [7:0] FLAGS_BOR_SET = 8'h0c;
   localparam logic [7:0] FLAGS_BOR_KEEP = 8'h02;
   localparam logic [1:0] STATUS_POR = 2'b11;
   localparam int ST_TO = 1;
   localparam int ST_PD = 0;

   // ==========================================
   // vectors and widths
   localparam int PC_W = 15;
   localparam logic [14:0] RESET_VECTOR = 15'h0000;
   localparam logic [14:0] IRQ_VECTOR = 15'h0004;
   localparam logic [14:0] PC_ONE = 15'h0001;
   localparam int NUM_EV = 8;

   // ==========================================
   // event index in interrupt status
   localparam int EV_POR = 0;
   localparam int EV_BOR = 1;
   localparam int EV_PIN = 2;
   localparam int EV_WDT = 3;
   localparam int EV_INSTR = 4;
   localparam int EV_STACK = 5;
   localparam int EV_WAKE_WDT = 6;
   localparam int EV_WAKE_IRQ = 7;

   // event inputs
   typedef struct packed {
      logic por;
      logic bor;
      logic pin;
      logic wdt;
      logic instr;
      logic stk_over;
      logic stk_under;
      logic irq_wake;
   } rcr_events_t;

   // register block state
   typedef struct packed {
      logic [7:0] flags;
      logic [1:0] status;
      logic [7:0] irq_stat;
      logic [7:0] irq_mask;
      logic [14:0] pc;
      logic pc_load;
      logic [7:0] rdata;
      logic pin_s1;
      logic pin_s2;
      logic pin_s3;
      logic pin_agreed;
      logic irq_vec_pending;
   } rcr_state_t;
endpackage : rcr_pkg

// [hdl/rcr_recorder.sv]
module rcr_recorder (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // register port
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // reset and wake sources, one-cycle pulses from core logic
   input wire rcr_pkg::rcr_events_t events_in,
   // external reset pin level, active low, asynchronous
   input wire logic external_reset_pin_n_in,
   // core context
   input wire logic sleeping_in,
   input wire logic stack_reset_option_in,
   input wire logic global_irq_enable_in,
   input wire logic [rcr_pkg::PC_W-1:0] pc_in,
   // program counter load, reset cause and interrupt request
   output logic [rcr_pkg::PC_W-1:0] pc_out,
   output logic pc_load_out,
   output logic [1:0] status_bits_out,
   output logic [7:0] reset_cause_flags_out,
   output logic irq_out
);
   rcr_pkg::rcr_state_t s_q;
   rcr_pkg::rcr_state_t s_d;
   // decoded strobes and events of the current cycle
   logic flags_wr;
   logic mask_wr;
   logic stat_rd;
   logic pin_ev;
   logic wake_irq;
   logic wake_wdt;
   logic wdt_reset;
   logic stack_hit;
   logic true_reset;
   logic [rcr_pkg::NUM_EV-1:0] ev_set;

   // register read mux, unimplemented bits zero
   function automatic logic [7:0] read_mux(input logic [3:0] a, input rcr_pkg::rcr_state_t s);
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         rcr_pkg::ADDR_FLAGS: r = s.flags & rcr_pkg::FLAGS_IMPL_MASK;
         rcr_pkg::ADDR_STATUS: r = {6'h00, s.status};
         rcr_pkg::ADDR_IRQ_STAT: r = s.irq_stat;
         rcr_pkg::ADDR_IRQ_MASK: r = s.irq_mask;
         rcr_pkg::ADDR_PC: r = s.pc[7:0];
         default: r = 8'h00;
      endcase
      return r;
   endfunction : read_mux

   // ==========================================
   // flag update functions

   // power-on: pin and instruction flags set, stack and supply flags clear
   // the brown-out flag has no defined value here and is taken as clear
   function automatic logic [7:0] por_flags(input logic [7:0] f);
      logic [7:0] r;
      r = (f & rcr_pkg::FLAGS_POR_KEEP) | rcr_pkg::FLAGS_POR_VAL;
      r[rcr_pkg::BIT_POR] = 1'b0;
      r[rcr_pkg::BIT_BOR] = 1'b0;
      return r & rcr_pkg::FLAGS_IMPL_MASK;
   endfunction : por_flags

   // brown-out: as power-on, but the power-on flag keeps its value
   function automatic logic [7:0] bor_flags(input logic [7:0] f);
      logic [7:0] r;
      r = (f & rcr_pkg::FLAGS_BOR_KEEP) | rcr_pkg::FLAGS_BOR_SET;
      r[rcr_pkg::BIT_BOR] = 1'b0;
      return r & rcr_pkg::FLAGS_IMPL_MASK;
   endfunction : bor_flags

   // pin reset: only the pin flag drops
   function automatic logic [7:0] pin_flags(input logic [7:0] f);
      logic [7:0] r;
      r = f;
      r[rcr_pkg::BIT_PIN] = 1'b0;
      return r;
   endfunction : pin_flags

   // reset instruction: only the instruction flag drops
   function automatic logic [7:0] instr_flags(input logic [7:0] f);
      logic [7:0] r;
      r = f;
      r[rcr_pkg::BIT_INSTR] = 1'b0;
      return r;
   endfunction : instr_flags

   // stack faults: the matching flag rises; only firmware, power-on or brown-out lowers it again
   function automatic logic [7:0] stack_flags(input logic [7:0] f, input logic over,
                                              input logic under);
      logic [7:0] r;
      r = f;
      if (over) begin
         r[rcr_pkg::BIT_OVF] = 1'b1;
      end
      if (under) begin
         r[rcr_pkg::BIT_UNF] = 1'b1;
      end
      return r;
   endfunction : stack_flags

   // firmware write: unimplemented positions never hold a one
   function automatic logic [7:0] written_flags(input logic [7:0] v);
      return v & rcr_pkg::FLAGS_IMPL_MASK;
   endfunction : written_flags

   // ==========================================
   // status update functions

   // pin reset: kept when awake; in sleep timeout rises and powerdown drops
   function automatic logic [1:0] pin_status(input logic [1:0] st, input logic asleep);
      logic [1:0] r;
      r = st;
      if (asleep) begin
         r[rcr_pkg::ST_TO] = 1'b1;
         r[rcr_pkg::ST_PD] = 1'b0;
      end
      return r;
   endfunction : pin_status

   // brown-out: timeout rises, powerdown keeps its value
   function automatic logic [1:0] bor_status(input logic [1:0] st);
      logic [1:0] r;
      r = st;
      r[rcr_pkg::ST_TO] = 1'b1;
      return r;
   endfunction : bor_status

   // watchdog: timeout drops; in sleep powerdown drops as well
   function automatic logic [1:0] wdt_status(input logic [1:0] st, input logic asleep);
      logic [1:0] r;
      r = st;
      r[rcr_pkg::ST_TO] = 1'b0;
      if (asleep) begin
         r[rcr_pkg::ST_PD] = 1'b0;
      end
      return r;
   endfunction : wdt_status

   // interrupt wake: timeout rises and powerdown drops
   function automatic logic [1:0] wake_status(input logic [1:0] st);
      logic [1:0] r;
      r = st;
      r[rcr_pkg::ST_TO] = 1'b1;
      r[rcr_pkg::ST_PD] = 1'b0;
      return r;
   endfunction : wake_status

   // ==========================================
   // program counter and pin helpers

   // address of the instruction after the sleep instruction, wraps at the top
   function automatic logic [rcr_pkg::PC_W-1:0] next_pc(input logic [rcr_pkg::PC_W-1:0] pc);
      return pc + rcr_pkg::PC_ONE;
   endfunction : next_pc

   // a low counts once, when stages two and three first agree on it;
   // a pin held low would otherwise raise a reset on every cycle
   function automatic logic pin_new_low(input rcr_pkg::rcr_state_t s);
      return (s.pin_s2 == s.pin_s3) && !s.pin_s3 && s.pin_agreed;
   endfunction : pin_new_low

   // level that the late stages agree on, else the level counted before;
   // a glitch seen by one stage only never changes it
   function automatic logic pin_level(input rcr_pkg::rcr_state_t s);
      logic r;
      r = s.pin_agreed;
      if (s.pin_s2 == s.pin_s3) begin
         r = s.pin_s3;
      end
      return r;
   endfunction : pin_level

   // interrupt request level from sticky events and mask
   function automatic logic irq_level(input rcr_pkg::rcr_state_t s);
      return |(s.irq_stat & s.irq_mask);
   endfunction : irq_level

   // ==========================================
   // event decode

   // register strobes
   assign flags_wr = wr_in && (addr_in == rcr_pkg::ADDR_FLAGS);
   assign mask_wr = wr_in && (addr_in == rcr_pkg::ADDR_IRQ_MASK);
   assign stat_rd = rd_in && (addr_in == rcr_pkg::ADDR_IRQ_STAT);

   // wake-ups only count while the core sleeps
   assign wake_irq = events_in.irq_wake && sleeping_in;
   assign wake_wdt = events_in.wdt && sleeping_in;

   // a watchdog expiry while awake is a true reset
   assign wdt_reset = events_in.wdt && !sleeping_in;

   // pin reset from the core or from the synchronised pin
   assign pin_ev = events_in.pin || pin_new_low(s_q);

   // stack faults only reset when the option is on
   assign stack_hit = stack_reset_option_in && (events_in.stk_over || events_in.stk_under);

   // every true reset, sleep wake-ups excluded
   assign true_reset = events_in.por || events_in.bor || pin_ev || wdt_reset
                       || events_in.instr || stack_hit;

   // one sticky status bit per source, the two stack faults sharing one
   always_comb begin
      ev_set = '0;
      ev_set[rcr_pkg::EV_POR] = events_in.por;
      ev_set[rcr_pkg::EV_BOR] = events_in.bor;
      ev_set[rcr_pkg::EV_PIN] = pin_ev;
      ev_set[rcr_pkg::EV_WDT] = wdt_reset;
      ev_set[rcr_pkg::EV_INSTR] = events_in.instr;
      ev_set[rcr_pkg::EV_STACK] = stack_hit;
      ev_set[rcr_pkg::EV_WAKE_WDT] = wake_wdt;
      ev_set[rcr_pkg::EV_WAKE_IRQ] = wake_irq;
   end

   // ==========================================
   // next state, lowest priority first so later sources win
   always_comb begin
      s_d = s_q;

      // three-stage pin synchroniser; stage one feeds only stage two
      s_d.pin_s1 = external_reset_pin_n_in;
      s_d.pin_s2 = s_q.pin_s1;
      s_d.pin_s3 = s_q.pin_s2;
      s_d.pin_agreed = pin_level(s_q);

      // read data of the addressed register, shown the cycle after
      s_d.rdata = read_mux(addr_in, s_q);
      s_d.pc_load = 1'b0;

      // firmware writes first so that hardware events below win
      if (flags_wr) begin
         s_d.flags = written_flags(wdata_in);
      end
      if (mask_wr) begin
         s_d.irq_mask = wdata_in;
      end

      // reading the event status clears it; new events set it again below
      if (stat_rd) begin
         s_d.irq_stat = 8'h00;
      end

      // vector load one cycle after an interrupt wake with interrupts enabled
      if (s_q.irq_vec_pending) begin
         s_d.irq_vec_pending = 1'b0;
         s_d.pc = rcr_pkg::IRQ_VECTOR;
         s_d.pc_load = 1'b1;
      end

      // interrupt wake: next instruction, then the vector if enabled
      if (wake_irq) begin
         s_d.status = wake_status(s_d.status);
         s_d.pc = next_pc(pc_in);
         s_d.pc_load = 1'b1;
         s_d.irq_vec_pending = global_irq_enable_in;
      end

      // watchdog wake: next instruction, never the vector
      if (wake_wdt) begin
         s_d.status = wdt_status(s_d.status, 1'b1);
         s_d.pc = next_pc(pc_in);
         s_d.pc_load = 1'b1;
         s_d.irq_vec_pending = 1'b0;
      end

      // watchdog reset while awake
      if (wdt_reset) begin
         s_d.status = wdt_status(s_d.status, 1'b0);
      end

      // reset instruction
      if (events_in.instr) begin
         s_d.flags = instr_flags(s_d.flags);
      end

      // stack faults
      if (stack_hit) begin
         s_d.flags = stack_flags(s_d.flags, events_in.stk_over, events_in.stk_under);
      end

      // pin reset, which also ends a sleep
      if (pin_ev) begin
         s_d.flags = pin_flags(s_d.flags);
         s_d.status = pin_status(s_d.status, sleeping_in);
      end

      // brown-out
      if (events_in.bor) begin
         s_d.flags = bor_flags(s_d.flags);
         s_d.status = bor_status(s_d.status);
      end

      // power-on overrides every other source
      if (events_in.por) begin
         s_d.flags = por_flags(s_d.flags);
         s_d.status = rcr_pkg::STATUS_POR;
      end

      // any true reset restarts at the reset vector and drops a pending vector
      if (true_reset) begin
         s_d.pc = rcr_pkg::RESET_VECTOR;
         s_d.pc_load = 1'b1;
         s_d.irq_vec_pending = 1'b0;
      end

      // sticky event bits, set wins over the read clear
      s_d.irq_stat = s_d.irq_stat | ev_set;
   end

   // ==========================================
   // state register, pin stages idle high so reset makes no false edge
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s_q <= '{flags: rcr_pkg::FLAGS_POR_VAL, status: rcr_pkg::STATUS_POR, irq_stat: 8'h00,
                  irq_mask: 8'h00, pc: rcr_pkg::RESET_VECTOR, pc_load: 1'b0,
                  rdata: 8'h00, pin_s1: 1'b1, pin_s2: 1'b1, pin_s3: 1'b1,
                  pin_agreed: 1'b1, irq_vec_pending: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================
   // outputs

   // registered read data
   assign rdata_out = s_q.rdata;

   // program counter load towards the core
   assign pc_out = s_q.pc;
   assign pc_load_out = s_q.pc_load;

   // reset cause as seen by the core
   assign status_bits_out = s_q.status;
   assign reset_cause_flags_out = s_q.flags & rcr_pkg::FLAGS_IMPL_MASK;

   // level interrupt while an unmasked event bit is set
   assign irq_out = irq_level(s_q);
endmodule : rcr_recorder

// [bench/rcr_recorder_sva.sv]
module rcr_recorder_sva (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // watched ports
   input wire rcr_pkg::rcr_events_t events_in,
   input wire logic wr_in,
   input wire logic sleeping_in,
   input wire logic stack_reset_option_in,
   input wire logic global_irq_enable_in,
   input wire logic [rcr_pkg::PC_W-1:0] pc_in,
   input wire logic [rcr_pkg::PC_W-1:0] pc_out,
   input wire logic pc_load_out,
   input wire logic [1:0] status_bits_out,
   input wire logic [7:0] reset_cause_flags_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);
   // ==========================================
   // reset causes and wake-ups
   por_result_a: assert property (events_in.por |=> reset_cause_flags_out == 8'h0c
      && status_bits_out == 2'b11 && pc_load_out && pc_out == 15'h0000) else $error("por bad");
   bor_result_a: assert property (events_in == 8'h40 |=> status_bits_out[1]
      && reset_cause_flags_out == (($past(reset_cause_flags_out) & 8'h02) | 8'h0c))
      else $error("bor bad");
   pin_clear_a: assert property (events_in == 8'h20 |=> pc_load_out && pc_out == 15'h0000
      && reset_cause_flags_out == ($past(reset_cause_flags_out) & 8'hf7)) else $error("pin bad");
   instr_clear_a: assert property (events_in == 8'h08
      |=> reset_cause_flags_out == ($past(reset_cause_flags_out) & 8'hfb))
      else $error("instr bad");
   over_set_a: assert property (events_in == 8'h04 && stack_reset_option_in
      |=> reset_cause_flags_out == ($past(reset_cause_flags_out) | 8'h80)) else $error("ovf bad");
   stack_sticky_a: assert property (!wr_in && reset_cause_flags_out[7] && !events_in.por
      && !events_in.bor |=> reset_cause_flags_out[7]) else $error("ovf lost");
   wdt_wake_a: assert property (events_in == 8'h10 && sleeping_in
      |=> status_bits_out == 2'b00 && pc_load_out && pc_out == $past(pc_in) + 15'h0001)
      else $error("wdt wake bad");
   irq_vector_a: assert property (events_in == 8'h01 && sleeping_in && global_irq_enable_in
      |=> status_bits_out == 2'b10 ##1 pc_load_out && pc_out == 15'h0004) else $error("vector bad");
   unimpl_zero_a: assert property (reset_cause_flags_out[5:4] == 2'b00) else $error("bits set");
   // ==========================================
   // main scenarios
   cover property (events_in.por);
   cover property (events_in == 8'h01 && sleeping_in && global_irq_enable_in);
   cover property (events_in == 8'h04 && stack_reset_option_in);
endmodule : rcr_recorder_sva

bind rcr_recorder rcr_recorder_sva i_sva (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
   .events_in(events_in), .wr_in(wr_in), .sleeping_in(sleeping_in), .pc_in(pc_in),
   .stack_reset_option_in(stack_reset_option_in), .global_irq_enable_in(global_irq_enable_in),
   .pc_out(pc_out), .pc_load_out(pc_load_out), .status_bits_out(status_bits_out),
   .reset_cause_flags_out(reset_cause_flags_out));

// [bench/rcr_recorder_tb.sv]
module rcr_recorder_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pin_n = 1'b1, slp = 1'b0;
   logic opt = 1'b0, global_irq_enable = 1'b0, pcl, irq;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, fl, d;
   logic [14:0] pc_i = 15'h1234, pc_o;
   logic [1:0] st;
   rcr_pkg::rcr_events_t ev = 8'h00;
   int errors = 0, n_tests = 0, cyc = 0;
   rcr_recorder i_dut (.ref_clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .events_in(ev), .external_reset_pin_n_in(pin_n),
      .sleeping_in(slp), .stack_reset_option_in(opt), .global_irq_enable_in(global_irq_enable), .pc_in(pc_i),
      .pc_out(pc_o), .pc_load_out(pcl), .status_bits_out(st), .reset_cause_flags_out(fl),
      .irq_out(irq));
   // ==========================================
   // clock and watchdog on the run
   initial begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         summarize();
      end
   end
   // ==========================================
   // helpers
   task chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task wreg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a; wdata <= v; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task rreg(input logic [3:0] a);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg
   task pulse(input logic [7:0] e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 8'h00;
      #1;
   endtask : pulse
   task summarize();
      $display("errors %0d tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   // ==========================================
   // scenarios
   task t_reset_regs();
      chk("flags", fl, 8'h0c);
      chk("status", st, 2'b11);
      rreg(4'hf);
      chk("unmapped", d, 8'h00);
      wreg(4'h0, 8'hff);
      rreg(4'h0);
      chk("rw flags", d, 8'hcf);
   endtask : t_reset_regs
   task t_por_vs_write();
      @(posedge clk);
      wr <= 1'b1; wdata <= 8'hff; addr <= 4'h0; ev <= 8'h80;
      @(posedge clk);
      wr <= 1'b0; ev <= 8'h00;
      #1 chk("por flags", fl, 8'h0c);
      chk("por pc", {pcl, pc_o}, 16'h8000);
   endtask : t_por_vs_write
   task t_bor_pin_instr();
      wreg(4'h0, 8'hcf);
      pulse(8'h40);
      chk("bor flags", fl, 8'h0e);
      pulse(8'h08);
      chk("instr flags", fl, 8'h0a);
      wreg(4'h0, 8'h0e);
      #1 chk("rewrite", fl, 8'h0e);
      @(posedge clk);
      slp <= 1'b1;
      pin_n <= 1'b0;
      repeat (8) @(posedge clk);
      pin_n <= 1'b1;
      slp <= 1'b0;
      #1 chk("pin flags", fl, 8'h06);
      chk("pin sleep", st, 2'b10);
   endtask : t_bor_pin_instr
   task t_stack_wdt_wake();
      pulse(8'h04);
      chk("no option", fl, 8'h06);
      @(posedge clk);
      opt <= 1'b1;
      pulse(8'h02);
      pulse(8'h04);
      pulse(8'h08);
      chk("stack sticky", fl, 8'hc2);
      pulse(8'h10);
      chk("wdt", {st, pc_o}, 17'h00000);
      @(posedge clk);
      slp <= 1'b1; global_irq_enable <= 1'b1;
      pulse(8'h10);
      chk("wdt wake", {st, pcl, pc_o}, 18'h09235);
      pulse(8'h01);
      chk("irq wake", {st, pcl, pc_o}, 18'h29235);
      @(posedge clk);
      #1 chk("vector", {pcl, pc_o}, 16'h8004);
   endtask : t_stack_wdt_wake
   task t_irq();
      wreg(4'h3, 8'h00);
      #1 chk("masked", irq, 1'b0);
      wreg(4'h3, 8'hff);
      #1 chk("raised", irq, 1'b1);
      rreg(4'h2);
      chk("irq stat", d, 8'hff);
      @(posedge clk);
      #1 chk("cleared", irq, 1'b0);
      rreg(4'h1);
      chk("status reg", d, 8'h02);
   endtask : t_irq
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      #1 t_reset_regs();
      t_por_vs_write();
      t_bor_pin_instr();
      t_stack_wdt_wake();
      t_irq();
      summarize();
   end
endmodule : rcr_recorder_tb
